// ===== design/oarp_pkg.sv
// Notes on behaviour
// - the report is four header time bytes, a set-number byte, a valid-count byte, then that many records.
// - multi-byte values go out most significant byte first, bit 7 is the msb.
// - the header time is the moment a complete valid almanac set was committed.
// - the commit time is kept in retained storage and only refreshed on a new set.
// - in legacy mode the report always carries sixteen records.
// - byte 0 bits 7..4 hold the record identifier, which implies no order.
// - byte 0 bit 3 is health, 1 healthy and 0 unhealthy.
// - byte 0 bits 2..1 are the network id, 0 net one, 1 net two, 2-3 reserved.
// - the 17-bit channel puts bit 16 in byte 0 bit 0, then bytes 1 and 2.
// - the 12-bit longitude fills byte 3 and the top nibble of byte 4.
// - service flags split across the low nibble of byte 4 and high of byte 5.
// - byte 5 bits 3..1 are reserved, bit 0 says week and time follow.
// - the 10-bit week fills byte 6 and byte 7 bits 7..6 when present.
// - the 14-bit minute count fills byte 7 bits 5..0 and byte 8 when present.
package oarp_pkg;

    // ------------------------------------------------------------------
    // sizes and counts
    // ------------------------------------------------------------------
    localparam int unsigned NUM_ENTRIES  = 16;
    localparam int unsigned IDX_W        = 4;
    localparam int unsigned LEGACY_COUNT = 16;
    localparam int unsigned REC_BASE_LEN = 6;
    localparam int unsigned REC_TIME_LEN = 9;
    localparam int unsigned FIFO_DEPTH   = 16;
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned TIME_W       = 32;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [3:0]  SET_NUM_RST  = 4'h0;
    localparam logic [4:0]  COUNT_RST    = 5'h00;
    localparam logic [31:0] COMMIT_T_RST = 32'h0000_0000;

    // one almanac entry as stored
    typedef struct packed {
        logic [3:0]  record_identifier;
        logic        healthy;
        logic [1:0]  network_id;
        logic [16:0] channel;
        logic [11:0] longitude;     // signed, 0.1 degree units
        logic [7:0]  service_flags;
        logic        time_included;
        logic [9:0]  gps_week;
        logic [13:0] time_of_week_minutes;
    } oarp_entry_s;

    // one output byte with framing marks
    typedef struct packed {
        logic       first;
        logic       last;
        logic [7:0] data;
    } oarp_byte_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_TIME = 5'b00010,
        ST_HDR  = 5'b00100,
        ST_REC  = 5'b01000,
        ST_DONE = 5'b10000
    } oarp_state_e;

endpackage

// ===== design/oarp_fifo.sv
`timescale 1ns/1ps
module oarp_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // ------------------------------------------------------------------
    // pointers and fill count
    // ------------------------------------------------------------------
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));   // full at DEPTH words
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// ===== design/oarp_packer.sv
`timescale 1ns/1ps
module oarp_packer
    import oarp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // almanac table load port
    input  wire logic                 entry_we,
    input  wire logic [IDX_W-1:0]     entry_idx,
    input  wire oarp_entry_s          entry_data,
    // commit of a complete verified set
    input  wire logic                 set_commit,
    input  wire logic [3:0]           set_number,
    input  wire logic [4:0]           set_valid_count,
    input  wire logic [TIME_W-1:0]    system_time,
    // report control
    input  wire logic                 legacy_mode,
    input  wire logic                 report_req,
    output logic                      report_busy,
    output logic [TIME_W-1:0]         commit_time,
    // byte stream out
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [BYTE_W-1:0]         out_data,
    output logic                      out_first,
    output logic                      out_last
);

    // ------------------------------------------------------------------
    // almanac table and set state
    // ------------------------------------------------------------------
    oarp_entry_s       table_q [NUM_ENTRIES];
    logic [3:0]        setn_q, setn_d;
    logic [4:0]        cnt_q, cnt_d;
    logic [TIME_W-1:0] ctime_q, ctime_d;

    // timestamp taken only on a new committed set, never on a report
    always_comb begin
        setn_d  = setn_q;
        cnt_d   = cnt_q;
        ctime_d = ctime_q;
        if (set_commit) begin
            setn_d  = set_number;
            cnt_d   = (set_valid_count > 5'd15) ? 5'd15 : set_valid_count;
            ctime_d = system_time;
        end
    end

    // ctime_q stands for the retained copy; its reset only models
    // a blank store on first power up
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setn_q  <= SET_NUM_RST;
            cnt_q   <= COUNT_RST;
            ctime_q <= COMMIT_T_RST;
        end else begin
            setn_q  <= setn_d;
            cnt_q   <= cnt_d;
            ctime_q <= ctime_d;
        end
    end

    always_ff @(posedge clk) begin
        if (entry_we) begin
            table_q[entry_idx] <= entry_data;
        end
    end

    assign commit_time = ctime_q;

    // ------------------------------------------------------------------
    // record byte layout
    // ------------------------------------------------------------------
    function automatic logic [7:0] rec_byte(input oarp_entry_s e,
                                            input logic [3:0] n);
        logic [7:0] b;
        b = 8'h00;
        case (n)
            4'd0: b = {e.record_identifier, e.healthy,
                       e.network_id, e.channel[16]};
            4'd1: b = e.channel[15:8];
            4'd2: b = e.channel[7:0];
            4'd3: b = e.longitude[11:4];
            4'd4: b = {e.longitude[3:0], e.service_flags[7:4]};
            4'd5: b = {e.service_flags[3:0], 3'b000,
                       e.time_included};
            4'd6: b = e.gps_week[9:2];
            4'd7: b = {e.gps_week[1:0],
                       e.time_of_week_minutes[13:8]};
            4'd8: b = e.time_of_week_minutes[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // report sequencer
    // ------------------------------------------------------------------
    oarp_state_e      st_q, st_d;
    logic [4:0]       rec_q, rec_d, nrec_q, nrec_d;
    logic [3:0]       byt_q, byt_d;
    logic [1:0]       tb_q, tb_d;
    logic             push;
    logic             f_ready;
    oarp_byte_s       f_in, f_out;
    logic [3:0]       rec_len;

    assign rec_len = table_q[rec_q[3:0]].time_included ?
                     4'(REC_TIME_LEN) : 4'(REC_BASE_LEN);

    always_comb begin
        st_d   = st_q;
        rec_d  = rec_q;
        nrec_d = nrec_q;
        byt_d  = byt_q;
        tb_d   = tb_q;
        push   = 1'b0;
        f_in   = '0;
        case (st_q)
            ST_IDLE: begin
                if (report_req) begin
                    nrec_d = legacy_mode ? 5'(LEGACY_COUNT) : cnt_q;
                    tb_d   = 2'd0;
                    st_d   = ST_TIME;
                end
            end
            ST_TIME: begin
                // header time, msb byte first
                push   = 1'b1;
                f_in.first = (tb_q == 2'd0);
                f_in.data  = ctime_q[8*(3-tb_q) +: 8];
                if (f_ready) begin
                    tb_d = tb_q + 2'd1;
                    if (tb_q == 2'd3) begin
                        tb_d = 2'd0;
                        st_d = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                push       = 1'b1;
                f_in.data  = (tb_q == 2'd0) ? {4'h0, setn_q}
                                            : {3'h0, nrec_q};
                f_in.last  = (tb_q == 2'd1) && (nrec_q == 5'd0);
                if (f_ready) begin
                    tb_d = tb_q + 2'd1;
                    if (tb_q == 2'd1) begin
                        rec_d = 5'd0;
                        byt_d = 4'd0;
                        st_d  = (nrec_q == 5'd0) ? ST_DONE : ST_REC;
                    end
                end
            end
            ST_REC: begin
                push      = 1'b1;
                f_in.data = rec_byte(table_q[rec_q[3:0]], byt_q);
                f_in.last = (byt_q == rec_len - 4'd1) &&
                            (rec_q == nrec_q - 5'd1);
                if (f_ready) begin
                    byt_d = byt_q + 4'd1;
                    if (byt_q == rec_len - 4'd1) begin
                        byt_d = 4'd0;
                        rec_d = rec_q + 5'd1;
                        if (rec_q == nrec_q - 5'd1) begin
                            st_d = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q   <= ST_IDLE;
            rec_q  <= 5'd0;
            nrec_q <= 5'd0;
            byt_q  <= 4'd0;
            tb_q   <= 2'd0;
        end else begin
            st_q   <= st_d;
            rec_q  <= rec_d;
            nrec_q <= nrec_d;
            byt_q  <= byt_d;
            tb_q   <= tb_d;
        end
    end

    // table writes during a report are the user's hazard: bytes already
    // sent are not redone
    assign report_busy = (st_q != ST_IDLE);

    // ------------------------------------------------------------------
    // output buffer; a stalled consumer stalls the sequencer
    // ------------------------------------------------------------------
    oarp_fifo #(
        .WIDTH ($bits(oarp_byte_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (f_ready),
        .in_data   (f_in),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (f_out)
    );

    assign out_data  = f_out.data;
    assign out_first = f_out.first;
    assign out_last  = f_out.last;
endmodule

// ===== sim/oarp_packer_checker.sv
`timescale 1ns/1ps
module oarp_packer_checker
    import oarp_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              set_commit,
    input wire logic [TIME_W-1:0] system_time,
    input wire logic              report_req,
    input wire logic              report_busy,
    input wire logic [TIME_W-1:0] commit_time,
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire logic [BYTE_W-1:0] out_data,
    input wire logic              out_first,
    input wire logic              out_last
);
    // ------------------------------------------------------------
    // stream and commit-time properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_req; report_req && !report_busy && !out_valid; endsequence
    sequence s_head; out_valid && out_first; endsequence
    sequence s_end; out_valid && out_ready && out_last; endsequence
    property p_start; report_req && !report_busy |=> report_busy; endproperty
    property p_answer; s_req |-> ##[1:3] s_head; endproperty
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data)
            && $stable(out_first) && $stable(out_last);
    endproperty
    property p_head; s_head |-> out_data == commit_time[31:24]; endproperty
    property p_excl; out_valid |-> !(out_first && out_last); endproperty
    property p_after; s_end |=> !out_valid || out_first; endproperty
    property p_commit;
        set_commit |=> commit_time == $past(system_time);
    endproperty
    property p_keep; !set_commit |=> $stable(commit_time); endproperty
    a_start: assert property (p_start) else $error("busy not set");
    a_answer: assert property (p_answer) else $error("no head");
    a_hold: assert property (p_hold) else $error("byte changed");
    a_head: assert property (p_head) else $error("bad time msb");
    a_excl: assert property (p_excl) else $error("first and last");
    a_after: assert property (p_after) else $error("stray byte");
    a_commit: assert property (p_commit) else $error("time lost");
    a_keep: assert property (p_keep) else $error("time moved");
endmodule

bind oarp_packer oarp_packer_checker u_chk (.clk, .resetn, .set_commit,
    .system_time, .report_req, .report_busy, .commit_time, .out_valid,
    .out_ready, .out_data, .out_first, .out_last);

// ===== sim/oarp_sink.sv
`timescale 1ns/1ps
module oarp_sink (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       hold,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    input  wire logic       first,
    input  wire logic       last,
    output logic            ready
);
    // ------------------------------------------------------------
    // report consumer
    // ------------------------------------------------------------
    logic [9:0] got[$];
    int         frames = 0;
    integer     seed   = 32'hd6df_4e5b;
    initial ready = 1'b0;
    // takes bytes in arrival order, record id not interpreted
    always @(posedge clk) begin
        if (resetn && valid && ready) begin
            got.push_back({first, last, data});
            if (last) frames++;
        end
        ready <= !hold && (($random(seed) & 3) != 0); // slow at times
    end
endmodule

// ===== sim/oarp_packer_test.sv
`timescale 1ns/1ps
module oarp_packer_test
    import oarp_pkg::*;
;
    logic              clk, resetn, entry_we, set_commit, legacy_mode;
    logic              report_req, report_busy, out_valid, out_ready;
    logic              out_first, out_last, hold;
    logic [IDX_W-1:0]  entry_idx;
    oarp_entry_s       entry_data, tbl[16];
    logic [3:0]        set_number;
    logic [4:0]        set_valid_count;
    logic [TIME_W-1:0] system_time, commit_time, exp_time;
    logic [BYTE_W-1:0] out_data;
    int                num_errors = 0, check_count = 0, exp_q[$];
    integer            seed = 32'hd6df_4e5b;

    oarp_packer u_dut (.clk, .resetn, .entry_we, .entry_idx, .entry_data,
        .set_commit, .set_number, .set_valid_count, .system_time,
        .legacy_mode, .report_req, .report_busy, .commit_time, .out_valid,
        .out_ready, .out_data, .out_first, .out_last);
    oarp_sink u_sink (.clk, .resetn, .hold, .valid(out_valid),
        .data(out_data), .first(out_first), .last(out_last),
        .ready(out_ready));

    // ------------------------------------------------------------
    // clock, watchdog, compares
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is under a thousand cycles
    initial begin
        #200_000;
        num_errors++;
        close_out();
    end
    task automatic chk_byte(input logic [9:0] got, input logic [9:0] want);
        check_count++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // reference model of the report
    // ------------------------------------------------------------
    task automatic build(input int cnt, input bit leg, input int sn);
        int n, ch, lo, fl, wk, tw;
        n = leg ? 16 : (cnt > 15 ? 15 : cnt);
        exp_q = {};
        for (int k = 3; k >= 0; k--) exp_q.push_back(exp_time[8*k+:8]);
        exp_q.push_back(sn);
        exp_q.push_back(n);
        for (int i = 0; i < n; i++) begin
            ch = tbl[i].channel;
            lo = tbl[i].longitude;
            fl = tbl[i].service_flags;
            wk = tbl[i].gps_week;
            tw = tbl[i].time_of_week_minutes;
            exp_q.push_back(tbl[i].record_identifier * 16 + tbl[i].healthy * 8
                + tbl[i].network_id * 2 + (ch >> 16));
            exp_q.push_back((ch >> 8) & 255);
            exp_q.push_back(ch & 255);
            exp_q.push_back(lo >> 4);
            exp_q.push_back((lo & 15) * 16 + (fl >> 4));
            exp_q.push_back((fl & 15) * 16 + tbl[i].time_included);
            if (tbl[i].time_included) begin
                exp_q.push_back(wk >> 2);
                exp_q.push_back((wk & 3) * 64 + (tw >> 8));
                exp_q.push_back(tw & 255);
            end
        end
    endtask

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic load();
        oarp_entry_s e;
        for (int i = 0; i < 16; i++) begin
            e = $random(seed);
            e.record_identifier = $random(seed);
            e.healthy = $random(seed);
            e.network_id = $random(seed) & 1;
            e.channel = ($random(seed) & 32'h00ff_ffff) % 70001;
            e.longitude = (($random(seed) & 32'hffff) % 3601) - 1800;
            e.time_of_week_minutes = ($random(seed) & 32'hffff) % 10080;
            if (i == 0) e = {4'hf, 3'h3, 17'd70000, -12'sd1800, 8'h81, 1'b1,
                10'd1023, 14'd10079}; // boundary values
            tbl[i] = e;
            @(posedge clk);
            entry_we   <= 1'b1;
            entry_idx  <= i;
            entry_data <= e;
        end
        @(posedge clk);
        entry_we <= 1'b0;
    endtask
    task automatic commit(input int sn, input int c);
        exp_time = $random(seed);
        @(posedge clk);
        set_commit      <= 1'b1;
        set_number      <= sn;
        set_valid_count <= c;
        system_time     <= exp_time;
        @(posedge clk);
        set_commit  <= 1'b0;
        system_time <= ~exp_time; // later time must not leak in
        repeat (2) @(posedge clk);
        chk_word(commit_time, exp_time);
    endtask
    task automatic run(input int cnt, input bit leg, input int sn,
                       input int hc);
        int f0, n, e;
        build(cnt, leg, sn);
        u_sink.got = {};
        f0 = u_sink.frames;
        @(posedge clk);
        hold        <= (hc > 0);
        report_req  <= 1'b1;
        legacy_mode <= leg;
        @(posedge clk);
        report_req <= 1'b0;
        @(posedge clk);
        report_req <= 1'b1; // arrives while busy, must be dropped
        @(posedge clk);
        report_req <= 1'b0;
        repeat (hc) @(posedge clk);
        hold <= 1'b0;
        for (int w = 0; w < 4000 && u_sink.frames == f0; w++) @(posedge clk);
        repeat (30) @(posedge clk);
        n = exp_q.size();
        chk_word(u_sink.got.size(), n);
        for (int k = 0; k < n && k < u_sink.got.size(); k++) begin
            e = exp_q[k] | ((k == 0) << 9) | ((k == n - 1) << 8);
            chk_byte(u_sink.got[k], e);
        end
        chk_word(commit_time, exp_time);
        chk_word(report_busy, 32'h0000_0000); // back to idle
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, entry_we, set_commit, legacy_mode, report_req} = '0;
        {entry_idx, set_number, set_valid_count, system_time} = '0;
        entry_data = '0;
        hold = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk_word(commit_time, 32'h0000_0000);
        load();
        commit(7, 20);
        run(20, 1'b0, 7, 40);
        run(15, 1'b0, 7, 0);
        commit(3, 0);
        run(0, 1'b0, 3, 0);
        commit(15, 5);
        run(5, 1'b1, 15, 0);
        close_out();
    end
endmodule
